// ===== design/pcl_cycle_timer.sv
`timescale 1ns/100ps
module pcl_cycle_timer #(
    parameter int W = 25
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [W-1:0] period,
    output logic busy,
    output logic done
);
    logic [W-1:0] count_ff;

    // Down counter, a start reloads it even while running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else if (start) begin
            count_ff <= period;
        end else if (count_ff != '0) begin
            count_ff <= count_ff - W'(1);
        end
    end

    assign busy = (count_ff != '0);
    // Done marks the last counted cycle, so a reload on it keeps the period exact
    assign done = (count_ff == W'(1));
endmodule : pcl_cycle_timer

// ===== design/pcl_phy_config.sv
`timescale 1ns/100ps
module pcl_phy_config import pcl_pkg::*; #(
    parameter longint BLINK_HALF_CYC = PCL_BLINK_HALF_CYC,
    parameter longint PULSE_CYC = PCL_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    // Strap-only pins
    input wire logic negotiate_strap,
    input wire logic nego_mode_strap_lo,
    input wire logic nego_mode_strap_hi,
    input wire logic auto_xover_strap,
    input wire logic led_mode_strap,
    // Shared pins: collision and receive nibble, strap in / data out
    input wire logic col_pin_i,
    output logic col_pin_o,
    output logic col_pin_oe,
    input wire logic [3:0] rxd_pin_i,
    output logic [3:0] rxd_pin_o,
    output logic [3:0] rxd_pin_oe,
    output logic rx_dv_o,
    // Register port from the management frame decoder
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Status from negotiation, crossover and line logic
    input wire logic link_up,
    input wire pcl_mode_s nego_result,
    input wire logic parallel_detect,
    input wire logic auto_swap_req,
    input wire logic collision,
    // MII transmit side from the MAC, line data
    input wire pcl_nib_s mac_tx,
    input wire pcl_nib_s line_rx,
    output pcl_nib_s line_tx,
    output pcl_nib_s mac_rx,
    // Resolved configuration
    output pcl_mode_s op_mode,
    output logic an_enabled,
    output logic mdix_swap,
    output logic [3:0] near_loop_sel,
    output logic far_loop,
    output logic [4:0] station_addr,
    // Lamps
    output logic link_lamp,
    output logic speed_lamp,
    output logic activity_lamp
);
    localparam int TW = PCL_TMR_W;

    pcl_phase_e phase_ff;
    logic [9:0] strap_s1_ff;
    logic [9:0] strap_s2_ff;
    logic [15:0] advert_ff;
    logic [15:0] phyctl_ff;
    logic [15:0] testloop_ff;
    logic [15:0] ledctl_ff;
    logic [4:0] station_addr_ff;
    logic negotiate_strap_ff;
    logic [1:0] mode_code_ff;
    pcl_mode_s op_mode_ff;
    logic mdix_ff;
    pcl_nib_s line_tx_ff;
    pcl_nib_s mac_rx_ff;
    logic col_ff;
    logic [15:0] rdata_ff;
    logic rvalid_ff;
    logic blink_ff;
    logic link_lamp_ff;
    logic speed_lamp_ff;
    logic act_lamp_ff;
    logic sampling;
    logic wr_ok;
    logic [1:0] strap_code;
    logic [3:0] nxt_abil;
    logic [1:0] blink_sel;
    logic [1:0] pulse_sel;
    logic [TW-1:0] blink_period;
    logic [TW-1:0] pulse_period;
    logic blink_busy;
    logic blink_done;
    logic pulse_busy;
    logic mode1;
    logic mode3;
    logic [3:0] near_sel;
    logic near_any;
    logic nxt_link;
    logic nxt_act;

    // Two stages on every pin; no reset so they track the pins during reset
    always_ff @(posedge core_clk) begin
        strap_s1_ff <= {led_mode_strap, auto_xover_strap, negotiate_strap,
                        nego_mode_strap_hi, nego_mode_strap_lo, rxd_pin_i, col_pin_i};
        strap_s2_ff <= strap_s1_ff;
    end

    // Pin bits 0..4 form the address: collision is bit 0, receive 0..3 give 1..4
    assign strap_code = strap_s2_ff[6:5];

    // Sample once at the first edge after release, then pins turn to outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= PCL_PH_SAMPLE;
        end else begin
            case (phase_ff)
                PCL_PH_SAMPLE: phase_ff <= PCL_PH_RUN;
                PCL_PH_RUN: phase_ff <= PCL_PH_RUN;
                default: phase_ff <= PCL_PH_SAMPLE;
            endcase
        end
    end

    assign sampling = (phase_ff == PCL_PH_SAMPLE);
    assign wr_ok = reg_wr && !sampling;

    // Latched straps: address, negotiation enable, mode code
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            station_addr_ff <= 5'h00;
            negotiate_strap_ff <= 1'b0;
            mode_code_ff <= 2'h0;
        end else if (sampling) begin
            station_addr_ff <= strap_s2_ff[4:0];
            negotiate_strap_ff <= strap_s2_ff[7];
            mode_code_ff <= strap_code;
        end
    end

    // Ability bits from the straps
    always_comb begin
        if (strap_s2_ff[7]) begin
            case (strap_code)
                2'h0: nxt_abil = PCL_ADV_10_HF;
                2'h1: nxt_abil = PCL_ADV_100_HF;
                2'h2: nxt_abil = PCL_ADV_HALF_ONLY;
                default: nxt_abil = PCL_ADV_ALL;
            endcase
        end else begin
            nxt_abil = PCL_ADV_FORCED_BASE << strap_code;
        end
    end

    // Advertisement register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            advert_ff <= PCL_ADVERT_RST;
        end else if (sampling) begin
            advert_ff[PCL_ADV_ABIL_LSB +: 4] <= nxt_abil;
        end else if (wr_ok && reg_addr == PCL_OFS_ADVERT) begin
            advert_ff <= reg_wdata;
        end
    end

    // PHY control: auto crossover enable comes up set unless strapped off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phyctl_ff <= PCL_PHYCTL_RST;
        end else if (sampling) begin
            phyctl_ff[PCL_PHY_AUTO_XO] <= strap_s2_ff[8];
        end else if (wr_ok && reg_addr == PCL_OFS_PHYCTL) begin
            phyctl_ff <= reg_wdata;
        end
    end

    // Loop control register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            testloop_ff <= PCL_TESTLOOP_RST;
        end else if (wr_ok && reg_addr == PCL_OFS_TESTLOOP) begin
            testloop_ff <= reg_wdata;
        end
    end

    // Lamp control: mode low bit may come from its strap
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ledctl_ff <= PCL_LEDCTL_RST;
        end else if (sampling) begin
            ledctl_ff[PCL_LED_MODE_LO] <= strap_s2_ff[9];
        end else if (wr_ok && reg_addr == PCL_OFS_LEDCTL) begin
            ledctl_ff <= reg_wdata;
        end
    end

    // Read answer one cycle after the strobe; holes read zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    PCL_OFS_ADVERT: rdata_ff <= advert_ff;
                    PCL_OFS_PHYCTL: rdata_ff <= phyctl_ff;
                    PCL_OFS_TESTLOOP: rdata_ff <= testloop_ff;
                    PCL_OFS_LEDCTL: rdata_ff <= ledctl_ff;
                    default: rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    // Operating mode; with negotiation strapped on, a parallel-detected partner only ever gets half duplex
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_mode_ff <= '0;
        end else if (negotiate_strap_ff) begin
            op_mode_ff.speed_100 <= nego_result.speed_100;
            op_mode_ff.full <= nego_result.full && !parallel_detect;
        end else begin
            op_mode_ff.speed_100 <= mode_code_ff[1];
            op_mode_ff.full <= mode_code_ff[0];
        end
    end

    // Force wins; auto does not look at speed or negotiation state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdix_ff <= 1'b0;
        end else if (phyctl_ff[PCL_PHY_FORCE_XO]) begin
            mdix_ff <= 1'b1;
        end else if (phyctl_ff[PCL_PHY_AUTO_XO]) begin
            mdix_ff <= auto_swap_req;
        end else begin
            mdix_ff <= 1'b0;
        end
    end

    // PCS loop only exists in 100 Mb/s
    assign near_sel = testloop_ff[PCL_TL_ANA:PCL_TL_MII]
                      & {2'b11, op_mode_ff.speed_100, 1'b1};
    assign near_any = |near_sel;

    // Data paths: near loop echoes transmit, far loop turns received data round
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_tx_ff <= '0;
            mac_rx_ff <= '0;
            col_ff <= 1'b0;
        end else begin
            if (testloop_ff[PCL_TL_FAR]) begin
                line_tx_ff <= line_rx;
                mac_rx_ff <= line_rx;
                col_ff <= 1'b0;
            end else if (near_any) begin
                line_tx_ff <= mac_tx;
                mac_rx_ff <= mac_tx;
                col_ff <= 1'b0;
            end else begin
                line_tx_ff <= mac_tx;
                mac_rx_ff <= line_rx;
                col_ff <= collision;
            end
        end
    end

    // Lamp timer periods; each code step halves the time
    assign blink_sel = ledctl_ff[PCL_LED_BLINK_LSB +: 2];
    assign pulse_sel = ledctl_ff[PCL_LED_PULSE_LSB +: 2];
    assign blink_period = TW'(BLINK_HALF_CYC) >> blink_sel;
    assign pulse_period = TW'(PULSE_CYC) >> pulse_sel;

    // Free-running half-period timer for the blink phase
    pcl_cycle_timer #(
        .W(TW)
    ) u_blink (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(!blink_busy || blink_done),
        .period(blink_period),
        .busy(blink_busy),
        .done(blink_done)
    );

    // Retriggerable stretch of activity so short frames stay visible
    pcl_cycle_timer #(
        .W(TW)
    ) u_pulse (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(mac_tx.en || line_rx.en),
        .period(pulse_period),
        .busy(pulse_busy),
        .done()
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_ff <= 1'b0;
        end else if (blink_done) begin
            blink_ff <= !blink_ff;
        end
    end

    assign mode1 = ledctl_ff[PCL_LED_MODE_LO];
    assign mode3 = !ledctl_ff[PCL_LED_MODE_LO] && ledctl_ff[PCL_LED_MODE_HI];

    // Lamp sources by mode
    always_comb begin
        if (mode1) begin
            nxt_link = link_up;
            nxt_act = pulse_busy;
        end else begin
            nxt_link = link_up && !(pulse_busy && blink_ff);
            nxt_act = mode3 && op_mode_ff.full;
        end
    end

    // Lamp pins registered, each with its own polarity bit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_lamp_ff <= 1'b0;
            speed_lamp_ff <= 1'b0;
            act_lamp_ff <= 1'b0;
        end else begin
            link_lamp_ff <= nxt_link ^ ledctl_ff[PCL_LED_POL_LINK];
            speed_lamp_ff <= op_mode_ff.speed_100 ^ ledctl_ff[PCL_LED_POL_SPEED];
            act_lamp_ff <= nxt_act ^ ledctl_ff[PCL_LED_POL_ACT];
        end
    end

    // Shared pins stay released while straps are being read
    assign col_pin_o = col_ff;
    assign col_pin_oe = !sampling;
    assign rxd_pin_o = mac_rx_ff.d;
    assign rxd_pin_oe = {4{!sampling}};
    assign rx_dv_o = mac_rx_ff.en;

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign line_tx = line_tx_ff;
    assign mac_rx = mac_rx_ff;
    assign op_mode = op_mode_ff;
    assign an_enabled = negotiate_strap_ff;
    assign mdix_swap = mdix_ff;
    assign near_loop_sel = near_sel;
    assign far_loop = testloop_ff[PCL_TL_FAR];
    assign station_addr = station_addr_ff;
    assign link_lamp = link_lamp_ff;
    assign speed_lamp = speed_lamp_ff;
    assign activity_lamp = act_lamp_ff;
endmodule : pcl_phy_config

// ===== design/pcl_pkg.sv
package pcl_pkg;
    // Register offsets on the management port
    localparam logic [4:0] PCL_OFS_ADVERT = 5'h04;
    localparam logic [4:0] PCL_OFS_PHYCTL = 5'h10;
    localparam logic [4:0] PCL_OFS_TESTLOOP = 5'h16;
    localparam logic [4:0] PCL_OFS_LEDCTL = 5'h18;
    // Field positions
    localparam int PCL_ADV_ABIL_LSB = 5;
    localparam int PCL_PHY_AUTO_XO = 6;
    localparam int PCL_PHY_FORCE_XO = 5;
    localparam int PCL_TL_MII = 0;
    localparam int PCL_TL_PCS = 1;
    localparam int PCL_TL_DIG = 2;
    localparam int PCL_TL_ANA = 3;
    localparam int PCL_TL_FAR = 4;
    localparam int PCL_LED_MODE_LO = 5;
    localparam int PCL_LED_MODE_HI = 6;
    localparam int PCL_LED_BLINK_LSB = 8;
    localparam int PCL_LED_PULSE_LSB = 13;
    localparam int PCL_LED_POL_LINK = 0;
    localparam int PCL_LED_POL_SPEED = 1;
    localparam int PCL_LED_POL_ACT = 2;
    // Values after reset, before the straps are folded in
    localparam logic [15:0] PCL_ADVERT_RST = 16'h0001;
    localparam logic [15:0] PCL_PHYCTL_RST = 16'h0040;
    localparam logic [15:0] PCL_TESTLOOP_RST = 16'h0000;
    localparam logic [15:0] PCL_LEDCTL_RST = 16'h0020;
    // Advertised abilities per mode strap code, bits 8:5 = 100F,100H,10F,10H
    localparam logic [3:0] PCL_ADV_10_HF = 4'h3;
    localparam logic [3:0] PCL_ADV_100_HF = 4'hc;
    localparam logic [3:0] PCL_ADV_HALF_ONLY = 4'h5;
    localparam logic [3:0] PCL_ADV_ALL = 4'hf;
    localparam logic [3:0] PCL_ADV_FORCED_BASE = 4'h1;
    // Lamp timing
    localparam longint PCL_CLK_HZ = 100_000_000;
    localparam longint PCL_BLINK_DEF_HZ = 5;
    localparam longint PCL_PULSE_DEF_MS = 200;
    localparam longint PCL_BLINK_HALF_CYC = PCL_CLK_HZ / (2 * PCL_BLINK_DEF_HZ);
    localparam longint PCL_PULSE_CYC = PCL_PULSE_DEF_MS * (PCL_CLK_HZ / 1000);
    localparam int PCL_TMR_W = 25;

    typedef struct packed {
        logic en;
        logic [3:0] d;
    } pcl_nib_s;

    typedef struct packed {
        logic speed_100;
        logic full;
    } pcl_mode_s;

    typedef enum logic {
        PCL_PH_SAMPLE,
        PCL_PH_RUN
    } pcl_phase_e;
endpackage : pcl_pkg

// ===== sim/pcl_mac_model.sv
`timescale 1ns/100ps
// MAC stand-in: register strobes and a transmit nibble stream
module pcl_mac_model import pcl_pkg::*; (
    input wire logic core_clk,
    input wire logic tx_run,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    output pcl_nib_s mac_tx
);
    int seed = 32'hacca;

    initial begin
        {reg_addr, reg_wr, reg_wdata, reg_rd, mac_tx} = '0;
    end

    // Enable stays up while running so the lamps see steady activity
    always @(negedge core_clk) begin
        mac_tx <= tx_run ? {1'b1, 4'($random(seed))} : 5'h00;
    end

    // One-cycle write strobe; data is scrambled once released
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr

    // Answer is registered off the strobe edge, so take it before dropping
    task automatic rd(input logic [4:0] a, output logic [16:0] g);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        g = {reg_rvalid, reg_rdata};
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : pcl_mac_model

// ===== sim/pcl_phy_config_sva.sv
`timescale 1ns/100ps
// Port-level checks on the configuration, loopback and shared-pin logic
module pcl_phy_config_sva import pcl_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic an_enabled,
    input wire logic parallel_detect,
    input wire pcl_mode_s op_mode,
    input wire logic [3:0] near_loop_sel,
    input wire logic far_loop,
    input wire pcl_nib_s mac_tx,
    input wire pcl_nib_s line_rx,
    input wire pcl_nib_s line_tx,
    input wire pcl_nib_s mac_rx,
    input wire logic col_pin_o,
    input wire logic col_pin_oe,
    input wire logic [3:0] rxd_pin_o,
    input wire logic [3:0] rxd_pin_oe,
    input wire logic rx_dv_o,
    input wire logic [4:0] station_addr
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Register answers come exactly one cycle after the read strobe
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    answer_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    // Duplex and speed checks
    detect_half_a: assert property (an_enabled && parallel_detect |=> !op_mode.full)
        else $error("full duplex under parallel detect");
    pcs_mask_a: assert property (!op_mode.speed_100 |-> !near_loop_sel[1])
        else $error("pcs loop at 10 Mb/s");
    // Datapath once a loop setting has been in place for a cycle
    near_return_a: assert property (
        !far_loop && near_loop_sel != 4'h0 ##1 !far_loop && near_loop_sel != 4'h0
        |-> mac_rx == $past(mac_tx) && line_tx == $past(mac_tx))
        else $error("near loop lost transmit data");
    far_return_a: assert property (
        far_loop ##1 far_loop |-> line_tx == $past(line_rx) && mac_rx == $past(line_rx))
        else $error("far loop path wrong");
    plain_path_a: assert property (
        !far_loop && near_loop_sel == 4'h0 ##1 !far_loop && near_loop_sel == 4'h0
        |-> line_tx == $past(mac_tx) && mac_rx == $past(line_rx))
        else $error("normal path wrong");
    loop_col_a: assert property (
        (far_loop || near_loop_sel != 4'h0) [*2] |-> !col_pin_o)
        else $error("collision shown in loop");
    // Shared pins after the strap sample cycle
    addr_hold_a: assert property (rst_n [*3] |-> $stable(station_addr))
        else $error("station address moved");
    pin_drive_a: assert property (rst_n [*3] |-> col_pin_oe && rxd_pin_oe == 4'hf)
        else $error("shared pins not driven");
    rx_pins_a: assert property (
        rst_n [*3] |-> rxd_pin_o == mac_rx.d && rx_dv_o == mac_rx.en)
        else $error("receive pins differ from nibble");
endmodule : pcl_phy_config_sva

bind pcl_phy_config pcl_phy_config_sva u_pcl_phy_config_sva (.*);

// ===== sim/test_phy_config_led_loopback.sv
`timescale 1ns/100ps
// Bench for straps, crossover, lamps and loopback
module test_phy_config_led_loopback import pcl_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic negotiate_strap, nego_mode_strap_lo, nego_mode_strap_hi;
    logic auto_xover_strap, led_mode_strap, col_strap, tx_run, rx_run;
    logic link_up, parallel_detect, auto_swap_req, collision, reg_wr, reg_rd, reg_rvalid;
    logic col_pin_o, col_pin_oe, rx_dv_o, an_enabled, mdix_swap, far_loop;
    logic link_lamp, speed_lamp, activity_lamp;
    logic [3:0] rxd_strap, rxd_pin_o, rxd_pin_oe, near_loop_sel;
    logic [4:0] reg_addr, station_addr, e;
    logic [15:0] reg_wdata, reg_rdata;
    wire col_pin_i;
    wire [3:0] rxd_pin_i;
    pcl_mode_s nego_result, op_mode;
    pcl_nib_s mac_tx, line_rx, line_tx, mac_rx;
    int miscompares = 0;
    int check_count = 0;
    int seed = 32'hacca;
    wire [4:0] lamps = {op_mode, speed_lamp, link_lamp, activity_lamp};

    always #5 core_clk = ~core_clk;

    // Shared pins show the strap level unless the design drives them
    assign col_pin_i = col_pin_oe ? col_pin_o : col_strap;
    assign rxd_pin_i = (rxd_pin_oe & rxd_pin_o) | (~rxd_pin_oe & rxd_strap);

    pcl_phy_config #(.BLINK_HALF_CYC(8), .PULSE_CYC(20)) u_pcl_phy_config (.*);
    pcl_mac_model u_pcl_mac_model (.*);

    // Random line traffic and collisions while running
    always @(negedge core_clk) begin
        if (rx_run) begin
            line_rx <= 5'($random(seed));
            collision <= 1'($random(seed));
        end
    end

    task automatic chk_val(string n, logic [16:0] x, logic [16:0] g);
        check_count++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask : chk_val

    task automatic chk_reg(logic [4:0] a, logic [15:0] x);
        logic [16:0] g;
        u_pcl_mac_model.rd(a, g);
        chk_val("register", {1'b1, x}, g);
    endtask : chk_reg

    task automatic final_report;
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // Abilities in bits 8:5 expected for a strap code
    function automatic logic [3:0] adv(logic [2:0] c);
        if (!c[2]) return 4'h1 << c[1:0];
        case (c[1:0])
            2'h0: return 4'h3;
            2'h1: return 4'hc;
            2'h2: return 4'h5;
            default: return 4'hf;
        endcase
    endfunction : adv

    // Lone PHY on the bus, so any random address is unique
    task automatic do_reset(logic [2:0] c);
        @(negedge core_clk);
        rst_n = 1'b0;
        {negotiate_strap, nego_mode_strap_hi, nego_mode_strap_lo} = c;
        {rxd_strap, col_strap, auto_xover_strap, led_mode_strap} = 7'($random(seed));
        repeat (5) @(negedge core_clk);
        chk_val("oe in reset", 17'h0, {col_pin_oe, rxd_pin_oe});
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_val("address", {rxd_strap, col_strap}, station_addr);
        chk_val("negotiate", c[2], an_enabled);
        if (!c[2]) chk_val("forced", c[1:0], op_mode);
        chk_reg(PCL_OFS_ADVERT, {7'h0, adv(c), 5'h1});
        chk_reg(PCL_OFS_PHYCTL, {9'h0, auto_xover_strap, 6'h0});
        chk_reg(PCL_OFS_LEDCTL, {10'h0, led_mode_strap, 5'h0});
        chk_reg(PCL_OFS_TESTLOOP, 16'h0);
        chk_reg(5'h05, 16'h0);
    endtask : do_reset

    // Cut a hung run short
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic [1:0] m;
        logic p;
        int n;
        {negotiate_strap, nego_mode_strap_lo, nego_mode_strap_hi, auto_xover_strap} = '0;
        {led_mode_strap, col_strap, rxd_strap, tx_run, rx_run, link_up} = '0;
        {parallel_detect, auto_swap_req, collision, nego_result, line_rx} = '0;
        for (int i = 0; i < 8; i++) do_reset(3'(i));
        // Crossover: force, automatic, off
        for (int i = 0; i < 8; i++) begin
            auto_swap_req = i[0];
            u_pcl_mac_model.wr(PCL_OFS_PHYCTL, {9'h0, i[2:1], 5'h0});
            repeat (2) @(negedge core_clk);
            chk_val("swap", i[1] | (i[2] & i[0]), mdix_swap);
        end
        // Random lamp modes and polarities without activity
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            {nego_result, parallel_detect, link_up} = r[3:0];
            u_pcl_mac_model.wr(PCL_OFS_LEDCTL, {9'h0, r[6:5], 2'h0, r[9:7]});
            repeat (3) @(negedge core_clk);
            m = {r[3], r[2] & !r[1]};
            e = {m, m[1] ^ r[8], r[0] ^ r[7], (r[6:5] == 2'h2 && m[0]) ^ r[9]};
            chk_val("lamps", e, lamps);
        end
        // Activity pulse widths in mode 1
        for (int c = 0; c < 3; c++) begin
            u_pcl_mac_model.wr(PCL_OFS_LEDCTL, 16'h0020 | 16'(c) << 13);
            line_rx = 5'h10;
            @(negedge core_clk);
            line_rx = 5'h00;
            repeat (3) @(negedge core_clk);
            chk_val("pulse on", 1'b1, activity_lamp);
            repeat ((20 >> c) + 1) @(negedge core_clk);
            chk_val("pulse off", 1'b0, activity_lamp);
        end
        // Blink rates under steady activity in mode 2
        link_up = 1'b1;
        tx_run = 1'b1;
        for (int b = 0; b < 3; b++) begin
            u_pcl_mac_model.wr(PCL_OFS_LEDCTL, 16'(b) << 8);
            repeat (2) @(negedge core_clk);
            n = 0;
            for (int k = 0; k < 32; k++) begin
                p = link_lamp;
                @(negedge core_clk);
                if (link_lamp !== p) n++;
            end
            p = n >= 32 / (8 >> b) - 1 && n <= 32 / (8 >> b) + 1;
            chk_val("blink", 1'b1, p);
        end
        // Loopback at 10 and 100 Mb/s with negotiation strapped off
        rx_run = 1'b1;
        for (int s = 0; s < 2; s++) begin
            do_reset({1'b0, s[0], s[0]});
            for (int k = 0; k < 5; k++) begin
                u_pcl_mac_model.wr(PCL_OFS_TESTLOOP, 16'h1 << k);
                repeat (8) @(negedge core_clk);
                e = (k == 1 && s == 0) ? 5'h00 : 5'h01 << k;
                chk_val("loop select", e, {far_loop, near_loop_sel});
                chk_reg(PCL_OFS_TESTLOOP, 16'h1 << k);
            end
        end
        final_report();
    end
endmodule : test_phy_config_led_loopback
